// file: rtl/shc_pkg.sv
// Summary of operation
// - sync circuit enable, bit 26 of reg eleven, resets to one
// - group sync exclusion bits 25:20; groups four and three excluded at reset
// - sync pin output select, bits 19:18, resets to zero (constant low)
// - bit 17 qualifies sync by a clock output; resets to zero
// - bit 16 sync input polarity; resets to one, low is active
// - bit 15 automatic sync; reset manual, output writes launch nothing
// - bit 5 crystal oscillator enable; resets to zero
// - lock pin select bits 31:27 of reg twelve resets to three
// - bit 23 holds outputs in sync until second loop locks
// - bit 22 holds outputs in sync until first loop locks
// - bit 8 dac tracks first loop tuning voltage; resets to one
// - holdover control bits 7:6 reset to two; unlock enters holdover
// - holdover pin select bits 31:27 of reg thirteen resets to seven
// - status pin one select bits 22:20 resets to zero
// - status pin zero kind bits 18:16 resets to two
// - bit 15 masks first loop unlock edge from entering holdover
// - status pin zero select bits 14:12 resets to zero
// - reference select mode bits 11:9 resets to three, manual
// - bit 8 inverts status pin inputs, only applied when mode is six
// - bits 6 and 5 mark reference inputs one and zero usable
// - signal loss timeout bits 31:30 of reg fourteen; code zero 1200 ns
// - bit 28 enables signal loss detection; resets to one
package shc_pkg;
  // register indices
  localparam logic [4:0] REG_SYNC_OSC = 5'h0B;
  localparam logic [4:0] REG_LOCK_HOLD = 5'h0C;
  localparam logic [4:0] REG_STATUS_REF = 5'h0D;
  localparam logic [4:0] REG_LOSS_BUF = 5'h0E;
  // reg eleven fields
  localparam int SYNC_EN_BIT = 26;
  localparam int GRP_EXCL_LSB = 20;
  localparam int SYNC_OUT_SEL_LSB = 18;
  localparam int SYNC_QUALIFY_BY_OUTPUT_BIT = 17;
  localparam int SYNC_POL_BIT = 16;
  localparam int SYNC_AUTO_BIT = 15;
  localparam int SYNC_KIND_LSB = 12;
  localparam int XTAL_EN_BIT = 5;
  // reg twelve fields
  localparam int LOCK_SEL_LSB = 27;
  localparam int LOCK_KIND_LSB = 24;
  localparam int HOLD_L2_BIT = 23;
  localparam int HOLD_L1_BIT = 22;
  localparam int TRACK_BIT = 8;
  localparam int HOLD_MODE_LSB = 6;
  // reg thirteen fields
  localparam int HOLD_SEL_LSB = 27;
  localparam int HOLD_KIND_LSB = 24;
  localparam int ST1_SEL_LSB = 20;
  localparam int ST0_KIND_LSB = 16;
  localparam int L1_MASK_BIT = 15;
  localparam int ST0_SEL_LSB = 12;
  localparam int REF_MODE_LSB = 9;
  localparam int ST_INV_BIT = 8;
  localparam int REF1_USE_BIT = 6;
  localparam int REF0_USE_BIT = 5;
  // reg fourteen fields
  localparam int LOSS_TMO_LSB = 30;
  localparam int LOSS_EN_BIT = 28;
  localparam int ST1_KIND_LSB = 24;
  localparam int REF1_BUF_BIT = 21;
  localparam int REF0_BUF_BIT = 20;
  // writable masks
  localparam logic [31:0] MASK_SYNC_OSC = 32'h07FF_F020;
  localparam logic [31:0] MASK_LOCK_HOLD = 32'hFFC0_01C0;
  localparam logic [31:0] MASK_STATUS_REF = 32'hFF7F_FF60;
  localparam logic [31:0] MASK_LOSS_BUF = 32'hD730_0000;
  // reset values
  localparam logic [31:0] RST_SYNC_OSC = 32'h0581_1000;
  localparam logic [31:0] RST_LOCK_HOLD = 32'h1B00_0180;
  localparam logic [31:0] RST_STATUS_REF = 32'h3B02_0660;
  localparam logic [31:0] RST_LOSS_BUF = 32'h1200_0000;
  // special codes
  localparam logic [2:0] REF_MODE_PIN_SEL = 3'h6;
  localparam logic [1:0] HOLD_MODE_AUTO = 2'h2;
  // signal loss timeout
  localparam int LOSS_TMO0_NS = 1200;
  localparam int CLK_PERIOD_NS = 20;
  localparam int LOSS_TMO0_CYC = LOSS_TMO0_NS / CLK_PERIOD_NS;

  // register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [31:0] wdata;
  } shc_bus_req_t;

  // decoded sync controls
  typedef struct packed {
    logic sync_enable;
    logic [5:0] group_sync_exclude;
    logic [1:0] sync_pin_select;
    logic sync_qualify_by_output;
    logic sync_pin_polarity;
    logic sync_auto;
    logic crystal_osc_enable;
  } shc_sync_cfg_t;

  // decoded reference and holdover controls
  typedef struct packed {
    logic [4:0] lock_pin_select;
    logic [4:0] holdover_pin_select;
    logic [2:0] status_pin0_select;
    logic [2:0] status_pin1_select;
    logic [2:0] status_pin0_kind;
    logic [2:0] status_pin1_kind;
    logic [2:0] reference_select_mode;
    logic ref_input0_usable;
    logic ref_input1_usable;
    logic dac_track;
    logic [1:0] holdover_mode;
    logic [1:0] signal_loss_timeout;
    logic signal_loss_detect_enable;
  } shc_ref_cfg_t;
endpackage

// file: rtl/shc_config_regs.sv
module shc_config_regs (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // register port
  input wire shc_pkg::shc_bus_req_t bus_i,
  output logic [31:0] rdata_o,
  // loop lock indications and status pins from outside
  input wire logic first_loop_lock_i,
  input wire logic second_loop_lock_i,
  input wire logic [1:0] status_pin_i,
  // decoded configuration
  output shc_pkg::shc_sync_cfg_t sync_cfg_o,
  output shc_pkg::shc_ref_cfg_t ref_cfg_o,
  // derived controls
  output logic sync_force_o,
  output logic auto_sync_launch_o,
  output logic holdover_trigger_o,
  output logic [1:0] status_pin_level_o,
  output logic [7:0] loss_timeout_cycles_o
);

  logic [31:0] sync_osc_ff;
  logic [31:0] lock_hold_ff;
  logic [31:0] status_ref_ff;
  logic [31:0] loss_buf_ff;
  logic [31:0] nxt_rdata;
  logic [1:0] l1_sync_ff;
  logic [1:0] l2_sync_ff;
  logic [1:0] st_meta_ff;
  logic [1:0] st_sync_ff;
  logic l1_prev_ff;
  logic wr_sync;
  logic wr_lock;
  logic wr_stat;
  logic wr_loss;

  // address match helper
  function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
    hit = (a == r);
  endfunction

  assign wr_sync = bus_i.wr && hit(bus_i.addr, shc_pkg::REG_SYNC_OSC);
  assign wr_lock = bus_i.wr && hit(bus_i.addr, shc_pkg::REG_LOCK_HOLD);
  assign wr_stat = bus_i.wr && hit(bus_i.addr, shc_pkg::REG_STATUS_REF);
  assign wr_loss = bus_i.wr && hit(bus_i.addr, shc_pkg::REG_LOSS_BUF);

  // sync and oscillator register
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sync_osc_ff <= shc_pkg::RST_SYNC_OSC;
    else if (wr_sync)
      sync_osc_ff <= bus_i.wdata & shc_pkg::MASK_SYNC_OSC;
  end

  // lock detect and holdover register
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      lock_hold_ff <= shc_pkg::RST_LOCK_HOLD;
    else if (wr_lock)
      lock_hold_ff <= bus_i.wdata & shc_pkg::MASK_LOCK_HOLD;
  end

  // status pin and reference select register
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      status_ref_ff <= shc_pkg::RST_STATUS_REF;
    else if (wr_stat)
      status_ref_ff <= bus_i.wdata & shc_pkg::MASK_STATUS_REF;
  end

  // signal loss and input buffer register
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      loss_buf_ff <= shc_pkg::RST_LOSS_BUF;
    else if (wr_loss)
      loss_buf_ff <= bus_i.wdata & shc_pkg::MASK_LOSS_BUF;
  end

  // read mux, unmapped reads zero
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    if (bus_i.rd)
    begin
      case (bus_i.addr)
        shc_pkg::REG_SYNC_OSC: nxt_rdata = sync_osc_ff;
        shc_pkg::REG_LOCK_HOLD: nxt_rdata = lock_hold_ff;
        shc_pkg::REG_STATUS_REF: nxt_rdata = status_ref_ff;
        shc_pkg::REG_LOSS_BUF: nxt_rdata = loss_buf_ff;
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // read data stands one cycle after the strobe
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= 32'h0000_0000;
    else
      rdata_o <= nxt_rdata;
  end

  // field decode
  always_comb
  begin
    sync_cfg_o.sync_enable = sync_osc_ff[shc_pkg::SYNC_EN_BIT];
    sync_cfg_o.group_sync_exclude = sync_osc_ff[shc_pkg::GRP_EXCL_LSB +: 6];
    sync_cfg_o.sync_pin_select = sync_osc_ff[shc_pkg::SYNC_OUT_SEL_LSB +: 2];
    sync_cfg_o.sync_qualify_by_output = sync_osc_ff[shc_pkg::SYNC_QUALIFY_BY_OUTPUT_BIT];
    sync_cfg_o.sync_pin_polarity = sync_osc_ff[shc_pkg::SYNC_POL_BIT];
    sync_cfg_o.sync_auto = sync_osc_ff[shc_pkg::SYNC_AUTO_BIT];
    sync_cfg_o.crystal_osc_enable = sync_osc_ff[shc_pkg::XTAL_EN_BIT];
    ref_cfg_o.lock_pin_select = lock_hold_ff[shc_pkg::LOCK_SEL_LSB +: 5];
    ref_cfg_o.dac_track = lock_hold_ff[shc_pkg::TRACK_BIT];
    ref_cfg_o.holdover_mode = lock_hold_ff[shc_pkg::HOLD_MODE_LSB +: 2];
    ref_cfg_o.holdover_pin_select = status_ref_ff[shc_pkg::HOLD_SEL_LSB +: 5];
    ref_cfg_o.status_pin1_select = status_ref_ff[shc_pkg::ST1_SEL_LSB +: 3];
    ref_cfg_o.status_pin0_kind = status_ref_ff[shc_pkg::ST0_KIND_LSB +: 3];
    ref_cfg_o.status_pin0_select = status_ref_ff[shc_pkg::ST0_SEL_LSB +: 3];
    ref_cfg_o.reference_select_mode = status_ref_ff[shc_pkg::REF_MODE_LSB +: 3];
    ref_cfg_o.ref_input1_usable = status_ref_ff[shc_pkg::REF1_USE_BIT];
    ref_cfg_o.ref_input0_usable = status_ref_ff[shc_pkg::REF0_USE_BIT];
    ref_cfg_o.status_pin1_kind = loss_buf_ff[shc_pkg::ST1_KIND_LSB +: 3];
    ref_cfg_o.signal_loss_timeout = loss_buf_ff[shc_pkg::LOSS_TMO_LSB +: 2];
    ref_cfg_o.signal_loss_detect_enable = loss_buf_ff[shc_pkg::LOSS_EN_BIT];
  end

  // two-stage synchronisers for outside levels
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      l1_sync_ff <= 2'h0;
      l2_sync_ff <= 2'h0;
      st_meta_ff <= 2'h0;
      st_sync_ff <= 2'h0;
    end
    else
    begin
      l1_sync_ff <= {l1_sync_ff[0], first_loop_lock_i};
      l2_sync_ff <= {l2_sync_ff[0], second_loop_lock_i};
      st_meta_ff <= status_pin_i;
      st_sync_ff <= st_meta_ff;
    end
  end

  // previous first loop lock for edge detect
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      l1_prev_ff <= 1'b0;
    else
      l1_prev_ff <= l1_sync_ff[1];
  end

  // sync forced until the selected loops report lock
  assign sync_force_o = (lock_hold_ff[shc_pkg::HOLD_L2_BIT] && !l2_sync_ff[1])
    || (lock_hold_ff[shc_pkg::HOLD_L1_BIT] && !l1_sync_ff[1]);

  // a write to an output register launches sync only in automatic mode
  assign auto_sync_launch_o = sync_osc_ff[shc_pkg::SYNC_AUTO_BIT] && bus_i.wr
    && (bus_i.addr < 5'h06);

  // in holdover mode two, unlock falling edge enters holdover unless masked
  assign holdover_trigger_o = (lock_hold_ff[shc_pkg::HOLD_MODE_LSB +: 2] == shc_pkg::HOLD_MODE_AUTO)
    && l1_prev_ff && !l1_sync_ff[1]
    && !status_ref_ff[shc_pkg::L1_MASK_BIT];

  // status pin inversion only in pin select mode
  assign status_pin_level_o = st_sync_ff ^ {2{status_ref_ff[shc_pkg::ST_INV_BIT]
    && (status_ref_ff[shc_pkg::REF_MODE_LSB +: 3] == shc_pkg::REF_MODE_PIN_SEL)}};

  // timeout count for code zero, others shifted left by the code within 8 bits
  assign loss_timeout_cycles_o = 8'(shc_pkg::LOSS_TMO0_CYC)
    << loss_buf_ff[shc_pkg::LOSS_TMO_LSB +: 2];

  // checks
  sequence s_l1_fall;
    l1_prev_ff && !l1_sync_ff[1];
  endsequence

  AST_SYNC_EN_RESET: assert property (@(posedge mclk_i) $rose(rst_n_i) |-> sync_cfg_o.sync_enable)
    else $error("sync enable not set after reset");
  AST_EXCL_RESET: assert property (@(posedge mclk_i) $rose(rst_n_i) |-> sync_cfg_o.group_sync_exclude == 6'h18)
    else $error("group exclusion reset wrong");
  AST_MANUAL_NO_LAUNCH: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !sync_cfg_o.sync_auto |-> !auto_sync_launch_o)
    else $error("manual mode launched sync");
  AST_HOLD_L2: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    lock_hold_ff[shc_pkg::HOLD_L2_BIT] && !l2_sync_ff[1] |-> sync_force_o)
    else $error("sync not forced for second loop");
  AST_HOLD_L1: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    lock_hold_ff[shc_pkg::HOLD_L1_BIT] && !l1_sync_ff[1] |-> sync_force_o)
    else $error("sync not forced for first loop");
  AST_HOLD_MASK: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    status_ref_ff[shc_pkg::L1_MASK_BIT] |-> !holdover_trigger_o)
    else $error("masked unlock entered holdover");
  AST_HOLD_TRIG: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_l1_fall ##0 (ref_cfg_o.holdover_mode == 2'h2 && !status_ref_ff[shc_pkg::L1_MASK_BIT])
    |-> holdover_trigger_o)
    else $error("unlock did not enter holdover");
  AST_INV_MODE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ref_cfg_o.reference_select_mode != 3'h6 |-> status_pin_level_o == st_sync_ff)
    else $error("inversion outside pin select mode");
  AST_LOSS_DEFAULT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ref_cfg_o.signal_loss_timeout == 2'h0 |-> loss_timeout_cycles_o == 8'd60)
    else $error("timeout count wrong");
  AST_READBACK: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    bus_i.rd && bus_i.addr == 5'h0E |=> rdata_o == loss_buf_ff)
    else $error("readback mismatch");

endmodule

// file: tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i;
  logic rst_n_i;
  shc_pkg::shc_bus_req_t bus_i;
  logic [31:0] rdata_o;
  logic first_loop_lock_i;
  logic second_loop_lock_i;
  logic [1:0] status_pin_i;
  shc_pkg::shc_sync_cfg_t sync_cfg_o;
  shc_pkg::shc_ref_cfg_t ref_cfg_o;
  logic sync_force_o;
  logic auto_sync_launch_o;
  logic holdover_trigger_o;
  logic [1:0] status_pin_level_o;
  logic [7:0] loss_timeout_cycles_o;
  int fail_count;
  int comparisons;
  int pulses;
  int bitpos;
  logic launch_seen;
  logic [4:0] idx [4];
  logic [31:0] rstv [4];
  logic [31:0] mask [4];
  shc_pkg::shc_sync_cfg_t exp_sync;
  shc_pkg::shc_ref_cfg_t exp_ref;

  shc_config_regs DUT (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .first_loop_lock_i(first_loop_lock_i), .second_loop_lock_i(second_loop_lock_i),
    .status_pin_i(status_pin_i), .sync_cfg_o(sync_cfg_o), .ref_cfg_o(ref_cfg_o),
    .sync_force_o(sync_force_o), .auto_sync_launch_o(auto_sync_launch_o),
    .holdover_trigger_o(holdover_trigger_o), .status_pin_level_o(status_pin_level_o),
    .loss_timeout_cycles_o(loss_timeout_cycles_o)
  );

  // free-running 50 MHz clock
  initial
  begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  // compare and count
  task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask

  // one-cycle write, launch flag sampled inside the strobe cycle
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    bus_i.wr <= 1'b1;
    bus_i.addr <= a;
    bus_i.wdata <= d;
    #1 launch_seen = auto_sync_launch_o;
    @(posedge mclk_i);
    bus_i.wr <= 1'b0;
  endtask

  // one-cycle read, data checked in the following cycle
  task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string what);
    @(posedge mclk_i);
    bus_i.rd <= 1'b1;
    bus_i.addr <= a;
    @(posedge mclk_i);
    bus_i.rd <= 1'b0;
    #1 chk(what, {8'h00, rdata_o}, {8'h00, exp});
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // hang guard, far beyond the fewer than two hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    stop_test();
  end

  // main sequence
  initial
  begin
    fail_count = 0;
    comparisons = 0;
    rst_n_i = 1'b0;
    bus_i = '0;
    first_loop_lock_i = 1'b0;
    second_loop_lock_i = 1'b0;
    status_pin_i = 2'b01;
    launch_seen = 1'b0;
    idx = '{shc_pkg::REG_SYNC_OSC, shc_pkg::REG_LOCK_HOLD, shc_pkg::REG_STATUS_REF, shc_pkg::REG_LOSS_BUF};
    rstv = '{shc_pkg::RST_SYNC_OSC, shc_pkg::RST_LOCK_HOLD, shc_pkg::RST_STATUS_REF, shc_pkg::RST_LOSS_BUF};
    mask = '{shc_pkg::MASK_SYNC_OSC, shc_pkg::MASK_LOCK_HOLD, shc_pkg::MASK_STATUS_REF, shc_pkg::MASK_LOSS_BUF};
    exp_sync = '{sync_enable: 1'b1, group_sync_exclude: 6'b01_1000, sync_pin_select: 2'h0,
      sync_qualify_by_output: 1'b0, sync_pin_polarity: 1'b1, sync_auto: 1'b0, crystal_osc_enable: 1'b0};
    exp_ref = '{lock_pin_select: 5'h03, holdover_pin_select: 5'h07, status_pin0_select: 3'h0,
      status_pin1_select: 3'h0, status_pin0_kind: 3'h2, status_pin1_kind: 3'h2,
      reference_select_mode: 3'h3, ref_input0_usable: 1'b1, ref_input1_usable: 1'b1, dac_track: 1'b1,
      holdover_mode: 2'h2, signal_loss_timeout: 2'h0, signal_loss_detect_enable: 1'b1};
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    // defaults after reset
    for (int i = 0; i < 4; i++)
      rd(idx[i], rstv[i], "reset value");
    rd(5'h10, 32'h0000_0000, "unmapped read");
    chk("sync decode", {27'h0, sync_cfg_o}, {27'h0, exp_sync});
    chk("ref decode", {7'h00, ref_cfg_o}, {7'h00, exp_ref});
    chk("loss timeout", {32'h0, loss_timeout_cycles_o}, 40'(1200 / 20));
    $display("test reset_values done");
    // writable bits and unmapped places
    for (int i = 0; i < 4; i++)
    begin
      wr(idx[i], 32'hFFFF_FFFF);
      rd(idx[i], mask[i], "all ones");
      wr(idx[i], 32'h0000_0000);
      rd(idx[i], 32'h0000_0000, "all zeros");
      wr(idx[i], rstv[i]);
    end
    wr(5'h0F, 32'hFFFF_FFFF);
    rd(5'h0F, 32'h0000_0000, "unmapped write");
    $display("test access done");
    // output-register writes launch sync only in automatic mode
    wr(5'h00, 32'h0000_0001);
    chk("manual launch", {39'h0, launch_seen}, 40'h0);
    wr(shc_pkg::REG_SYNC_OSC, shc_pkg::RST_SYNC_OSC | (32'h1 << shc_pkg::SYNC_AUTO_BIT));
    wr(5'h05, 32'h0000_0001);
    chk("auto launch", {39'h0, launch_seen}, 40'h1);
    wr(5'h06, 32'h0000_0001);
    chk("auto launch idx6", {39'h0, launch_seen}, 40'h0);
    wr(shc_pkg::REG_SYNC_OSC, shc_pkg::RST_SYNC_OSC);
    $display("test auto_sync done");
    // hold in sync until the selected loop locks
    for (int k = 0; k < 2; k++)
    begin
      bitpos = (k == 0) ? shc_pkg::HOLD_L2_BIT : shc_pkg::HOLD_L1_BIT;
      @(posedge mclk_i);
      first_loop_lock_i <= (k == 0);
      second_loop_lock_i <= (k == 1);
      repeat (4) @(posedge mclk_i);
      #1 chk("force off", {39'h0, sync_force_o}, 40'h0);
      wr(shc_pkg::REG_LOCK_HOLD, shc_pkg::RST_LOCK_HOLD | (32'h1 << bitpos));
      repeat (2) @(posedge mclk_i);
      #1 chk("force on", {39'h0, sync_force_o}, 40'h1);
      @(posedge mclk_i);
      first_loop_lock_i <= 1'b1;
      second_loop_lock_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      #1 chk("force released", {39'h0, sync_force_o}, 40'h0);
      wr(shc_pkg::REG_LOCK_HOLD, shc_pkg::RST_LOCK_HOLD);
    end
    $display("test sync_force done");
    // first-loop unlock enters holdover unless masked
    for (int k = 0; k < 2; k++)
    begin
      if (k == 1)
        wr(shc_pkg::REG_STATUS_REF, shc_pkg::RST_STATUS_REF | (32'h1 << shc_pkg::L1_MASK_BIT));
      @(posedge mclk_i);
      first_loop_lock_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      first_loop_lock_i <= 1'b0;
      pulses = 0;
      repeat (8)
      begin
        @(posedge mclk_i);
        #1 if (holdover_trigger_o === 1'b1) pulses++;
      end
      chk("holdover pulses", 40'(pulses), (k == 0) ? 40'h1 : 40'h0);
    end
    wr(shc_pkg::REG_STATUS_REF, shc_pkg::RST_STATUS_REF);
    $display("test holdover done");
    // status pin inversion applies only in pin-select mode
    repeat (3) @(posedge mclk_i);
    #1 chk("pins plain", {38'h0, status_pin_level_o}, 40'h1);
    wr(shc_pkg::REG_STATUS_REF, (shc_pkg::RST_STATUS_REF & ~(32'h7 << shc_pkg::REF_MODE_LSB))
      | (32'h6 << shc_pkg::REF_MODE_LSB) | (32'h1 << shc_pkg::ST_INV_BIT));
    repeat (3) @(posedge mclk_i);
    #1 chk("pins inverted", {38'h0, status_pin_level_o}, 40'h2);
    wr(shc_pkg::REG_STATUS_REF, shc_pkg::RST_STATUS_REF | (32'h1 << shc_pkg::ST_INV_BIT));
    repeat (3) @(posedge mclk_i);
    #1 chk("pins mode3", {38'h0, status_pin_level_o}, 40'h1);
    $display("test status_pins done");
    stop_test();
  end
endmodule
